// ===== rtl/sfra_core.sv
// Command interpreter for configuration, ECC status and register access of a serial flash
//
// Behaviour
// - Bits 7:5 select output impedance per table.
// - Multi-pass zero: reprogram disables unit ECC.
// - Multi-pass one: double detect, reprogram flags error.
// - Architecture option applies only after a reset.
// - Architecture option accepts one write, then locks.
// - Permanent lock refuses architecture option changes.
// - ECC status covers unit of last read.
// - Double-bit flag sticky, cleared by clear command.
// - Single-bit flag sticky; invalid when double set.
// - Opcode 9F returns maker and device bytes.
// - Opcode 5A, 3 address bytes, parameter table.
// - Opcode 4C returns 64-bit unique number.
// - Opcodes 05/07/35 return status and config.
// - Opcode 65 reads register at given address.
// - 06 sets latch, 04 clears, 50 volatile.
// - Opcode 01 writes up to six registers.
// - Opcode 71 writes one addressed register byte.
// - Opcode 82 clears erase and program fail.
// - B7 selects four-byte, B8 three-byte addresses.
// - Opcode 1B clears both ECC flags.
`timescale 1ns/1ps
module sfra_core
  import sfra_pkg::*;
#(
  parameter logic [7:0]  MAKER_ID      = 8'hA5,                  // Arbitrary value
  parameter logic [15:0] DEVICE_ID     = 16'h3C5A,               // Arbitrary value
  parameter logic [63:0] UNIQUE_NUMBER = 64'h0123_4567_89AB_CDEF, // Arbitrary value
  parameter logic [3:0]  ARCH_DEFAULT  = 4'h0
)(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        serial_clk,
  input  wire logic        chip_select_n,
  input  wire logic        serial_input_line,
  output logic             serial_output_line,
  output logic             serial_output_line_oe_n,
  input  wire logic        signaling_reset,
  input  wire logic        device_busy,
  input  wire logic        array_read_done,
  input  wire logic [31:0] array_read_addr,
  input  wire logic        ecc_single_detect,
  input  wire logic        ecc_double_detect,
  input  wire logic        unit_reprogram,
  input  wire logic        program_fail_set,
  input  wire logic        erase_fail_set,
  output logic [2:0]       drive_impedance_sel,
  output logic [7:0]       drive_impedance_ohm,
  output logic             multipass_ecc_sel,
  output logic             ecc_unit_disable,
  output logic [3:0]       sector_arch_option,
  output logic             sector_arch_locked,
  output logic             write_enable_latch,
  output logic             long_address_mode,
  output logic             blank_check_enable,
  output logic             erase_error_flag,
  output logic             program_error_flag,
  output logic             double_bit_error_flag,
  output logic             single_bit_error_flag,
  output logic             single_bit_flag_valid,
  output logic [27:0]      ecc_unit_addr
);

  localparam logic [7:0][7:0] PARAM_TABLE = {
    8'hFF, 8'h01, 8'h00, 8'h00, 8'h50, 8'h44, 8'h46, 8'h53
  };

  typedef struct packed {
    logic            tog;
    logic [2:0]      bit_cnt;
    logic [6:0]      shift;
    logic [7:0]      byte_cnt;
    logic [7:0]      opcode;
    logic [5:0][7:0] bytes;
    logic [7:0]      out_shift;
    logic            miso;
    logic            oe_n;
  } sfra_link_s;

  typedef struct packed {
    logic            cs_meta;
    logic            cs_sync;
    logic            cs_prev;
    logic            last_tog;
    logic [7:0]      status1;
    logic [7:0]      cfg1;
    logic [7:0]      cfg2;
    logic [7:0]      cfg3;
    logic [7:0]      cfg4;
    logic            vol_wen;
    logic [3:0]      arch_pending;
    logic            arch_locked;
    logic [3:0]      arch_active;
    logic            apply_arch;
    logic [7:0]      ecc_status;
    logic [27:0]     unit_addr;
    logic            unit_disable;
    logic [7:0]      imp_ohm;
    logic [7:0][7:0] snap;
  } sfra_ref_s;

  localparam sfra_link_s LINK_RESET = '{oe_n: 1'b1, default: '0};
  localparam sfra_ref_s REF_RESET = '{
    cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, last_tog: 1'b0,
    status1: STATUS_ONE_RESET, cfg1: CONFIG_ONE_RESET, cfg2: CONFIG_TWO_RESET,
    cfg3: CONFIG_THR_RESET, cfg4: CONFIG_FOU_RESET, vol_wen: 1'b0,
    arch_pending: ARCH_DEFAULT, arch_locked: 1'b0, arch_active: ARCH_DEFAULT,
    apply_arch: 1'b1, ecc_status: ECC_STATUS_RESET, unit_addr: '0,
    unit_disable: 1'b0, imp_ohm: 8'h2D, snap: '0
  };

  sfra_link_s link_reg;
  sfra_link_s link_next;
  sfra_ref_s  ref_reg;
  sfra_ref_s  ref_next;
  logic       link_open_reg;

  function automatic logic [7:0] impedance_ohm(input logic [2:0] sel);
    case (sel)
      3'h1:    impedance_ohm = 8'h78;
      3'h2:    impedance_ohm = 8'h5A;
      3'h3:    impedance_ohm = 8'h3C;
      3'h5:    impedance_ohm = 8'h1E;
      3'h6:    impedance_ohm = 8'h14;
      3'h7:    impedance_ohm = 8'h0F;
      default: impedance_ohm = 8'h2D;
    endcase
  endfunction

  function automatic logic [31:0] frame_addr(input logic [5:0][7:0] b, input logic long);
    frame_addr = long ? {b[0], b[1], b[2], b[3]} : {8'h00, b[0], b[1], b[2]};
  endfunction

  function automatic logic [7:0] snap_read(input logic [7:0][7:0] s, input sfra_reg_e r);
    snap_read = (r == REG_NONE) ? 8'h00 : s[3'(r)];
  endfunction

  // Byte position within the frame at which read data begins; zero for no read
  function automatic logic [8:0] data_start(input logic [7:0] op, input logic long);
    case (op)
      CMD_READ_IDENTIFICATION, CMD_READ_UNIQUE_NUMBER, CMD_READ_STATUS_ONE,
      CMD_READ_STATUS_TWO, CMD_READ_CONFIG_ONE:
        data_start = SHORT_READ_START;
      CMD_READ_PARAM_TABLE:  data_start = SHORT_READ_START + 9'h003 + DUMMY_BYTES;
      CMD_READ_ANY_REGISTER: data_start = SHORT_READ_START + (long ? 9'h004 : 9'h003)
                                          + DUMMY_BYTES;
      default:               data_start = 9'h000;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [8:0] idx,
                                           input logic [5:0][7:0] b, input logic long,
                                           input logic [7:0][7:0] s);
    logic [2:0] ptr;
    ptr = 3'(b[2]) + idx[2:0];
    read_byte = 8'h00;
    case (op)
      CMD_READ_IDENTIFICATION: begin
        if (idx == 9'h000) read_byte = MAKER_ID;
        else if (idx == 9'h001) read_byte = DEVICE_ID[15:8];
        else if (idx == 9'h002) read_byte = DEVICE_ID[7:0];
      end
      CMD_READ_UNIQUE_NUMBER: begin
        if (idx < UNIQUE_BYTES) read_byte = UNIQUE_NUMBER[8'(63 - 8 * idx) -: 8];
      end
      CMD_READ_STATUS_ONE:   read_byte = s[3'(REG_STATUS_ONE)];
      CMD_READ_STATUS_TWO:   read_byte = s[3'(REG_STATUS_TWO)];
      CMD_READ_CONFIG_ONE:   read_byte = s[3'(REG_CONFIG_ONE)];
      CMD_READ_PARAM_TABLE:  read_byte = PARAM_TABLE[ptr];
      CMD_READ_ANY_REGISTER: read_byte = snap_read(s, sfra_decode(frame_addr(b, long)));
      default:               read_byte = 8'h00;
    endcase
  endfunction

  function automatic sfra_reg_e write_order(input int k);
    case (k)
      0:       write_order = REG_STATUS_ONE;
      1:       write_order = REG_CONFIG_ONE;
      2:       write_order = REG_CONFIG_TWO;
      3:       write_order = REG_CONFIG_THR;
      4:       write_order = REG_CONFIG_FOU;
      5:       write_order = REG_SECTOR_ARC;
      default: write_order = REG_NONE;
    endcase
  endfunction

  // Non-volatile-backed fields need the full write enable, not the volatile one
  function automatic sfra_ref_s write_reg(input sfra_ref_s s, input sfra_reg_e r,
                                          input logic [7:0] d, input logic full_wen);
    write_reg = s;
    case (r)
      REG_STATUS_ONE: write_reg.status1 = (s.status1 & ~STATUS_ONE_WMASK)
                                          | (d & STATUS_ONE_WMASK);
      REG_CONFIG_ONE: begin
        write_reg.cfg1 = (s.cfg1 & ~CONFIG_ONE_WMASK) | (d & CONFIG_ONE_WMASK);
        if (full_wen && d[PERM_LOCK_BIT]) write_reg.cfg1[PERM_LOCK_BIT] = 1'b1;
      end
      REG_CONFIG_TWO: write_reg.cfg2 = (s.cfg2 & ~CONFIG_TWO_WMASK) | (d & CONFIG_TWO_WMASK);
      REG_CONFIG_THR: write_reg.cfg3 = (s.cfg3 & ~CONFIG_THR_WMASK) | (d & CONFIG_THR_WMASK);
      REG_CONFIG_FOU: write_reg.cfg4 = (s.cfg4 & ~CONFIG_FOU_WMASK) | (d & CONFIG_FOU_WMASK);
      REG_SECTOR_ARC: begin
        if (full_wen && !s.arch_locked && !s.cfg1[PERM_LOCK_BIT]) begin
          write_reg.arch_pending = d[ARCH_OPT_MSB:0];
          write_reg.arch_locked  = 1'b1;
        end
      end
      default: ;
    endcase
  endfunction

  // Link side: frame start is the first serial clock edge after chip select falls
  always_ff @(posedge serial_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      link_open_reg <= 1'b0;
    end else begin
      link_open_reg <= 1'b1;
    end
  end

  always_comb begin
    logic [2:0] bit_base;
    logic [7:0] byte_base;
    logic [7:0] byte_in;
    logic [7:0] op_now;
    logic [7:0] cur_out;
    logic [7:0] nb;
    logic [8:0] next_pos;
    logic [8:0] start;
    logic       long;
    bit_base  = link_open_reg ? link_reg.bit_cnt : 3'h0;
    byte_base = link_open_reg ? link_reg.byte_cnt : 8'h00;
    cur_out   = link_open_reg ? link_reg.out_shift : 8'h00;
    byte_in   = {link_reg.shift, serial_input_line};
    op_now    = (byte_base == 8'h00) ? byte_in : link_reg.opcode;
    long      = ref_reg.snap[3'(REG_CONFIG_TWO)][ADDR_LEN_BIT];
    next_pos  = {1'b0, byte_base} + 9'h001;
    start     = data_start(op_now, long);
    nb        = 8'h00;
    link_next = link_reg;
    if (!link_open_reg) begin
      link_next.tog  = ~link_reg.tog;
      link_next.oe_n = 1'b1;
    end
    link_next.bit_cnt   = bit_base + 3'h1;
    link_next.shift     = {link_reg.shift[5:0], serial_input_line};
    link_next.byte_cnt  = byte_base;
    link_next.miso      = cur_out[7];
    link_next.out_shift = {cur_out[6:0], 1'b0};
    if (bit_base == 3'h7) begin
      if (byte_base == 8'h00) begin
        link_next.opcode = byte_in;
      end else if (byte_base <= 8'h06) begin
        link_next.bytes[3'(byte_base - 8'h01)] = byte_in;
      end
      if (byte_base != 8'hFF) begin
        link_next.byte_cnt = byte_base + 8'h01;
      end
      if (start != 9'h000 && next_pos >= start) begin
        nb = read_byte(op_now, next_pos - start, link_reg.bytes, long, ref_reg.snap);
        link_next.miso      = nb[7];
        link_next.out_shift = {nb[6:0], 1'b0};
        link_next.oe_n      = 1'b0;
      end
    end
  end

  always_ff @(posedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      link_reg <= LINK_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  // Core side: frame fields are read only after chip select has risen and been synchronised
  always_comb begin
    logic       cs_rise;
    logic       cmd_go;
    logic       wel;
    logic       wr_ok;
    logic       long;
    logic [7:0] alen;
    ref_next  = ref_reg;
    cs_rise   = ref_reg.cs_sync & ~ref_reg.cs_prev;
    cmd_go    = cs_rise && (link_reg.tog != ref_reg.last_tog) && (link_reg.bit_cnt == 3'h0);
    wel       = ref_reg.status1[WEL_BIT];
    wr_ok     = wel | ref_reg.vol_wen;
    long      = ref_reg.cfg2[ADDR_LEN_BIT];
    alen      = long ? 8'h04 : 8'h03;
    ref_next.cs_meta      = chip_select_n;
    ref_next.cs_sync      = ref_reg.cs_meta;
    ref_next.cs_prev      = ref_reg.cs_sync;
    ref_next.unit_disable = 1'b0;
    ref_next.apply_arch   = 1'b0;
    if (cs_rise) begin
      ref_next.last_tog = link_reg.tog;
    end
    if (cmd_go) begin
      case (link_reg.opcode)
        CMD_WRITE_ENABLE:       ref_next.status1[WEL_BIT] = 1'b1;
        CMD_VOLATILE_WR_ENABLE: ref_next.vol_wen = 1'b1;
        CMD_WRITE_DISABLE: begin
          ref_next.status1[WEL_BIT] = 1'b0;
          ref_next.vol_wen          = 1'b0;
        end
        CMD_WRITE_REGISTERS: begin
          if (wr_ok && link_reg.byte_cnt >= 8'h02) begin
            for (int k = 0; k < 6; k++) begin
              if (8'(k) < link_reg.byte_cnt - 8'h01) begin
                ref_next = write_reg(ref_next, write_order(k), link_reg.bytes[k], wel);
              end
            end
            ref_next.status1[WEL_BIT] = 1'b0;
            ref_next.vol_wen          = 1'b0;
          end
        end
        CMD_WRITE_ANY_REGISTER: begin
          if (wr_ok && link_reg.byte_cnt == alen + 8'h02) begin
            ref_next = write_reg(ref_next, sfra_decode(frame_addr(link_reg.bytes, long)),
                                 link_reg.bytes[3'(alen)], wel);
            ref_next.status1[WEL_BIT] = 1'b0;
            ref_next.vol_wen          = 1'b0;
          end
        end
        CMD_CLEAR_FAIL_FLAGS: begin
          if (wel) begin
            ref_next.status1[ERASE_FAIL_BIT] = 1'b0;
            ref_next.status1[PROG_FAIL_BIT]  = 1'b0;
            ref_next.status1[WEL_BIT]        = 1'b0;
          end
        end
        CMD_ENTER_LONG_ADDRESS: ref_next.cfg2[ADDR_LEN_BIT] = 1'b1;
        CMD_EXIT_LONG_ADDRESS:  ref_next.cfg2[ADDR_LEN_BIT] = 1'b0;
        CMD_CLEAR_ECC_STATUS: begin
          if (wel) begin
            ref_next.ecc_status[DOUBLE_ERR_BIT] = 1'b0;
            ref_next.ecc_status[SINGLE_ERR_BIT] = 1'b0;
            ref_next.status1[WEL_BIT]           = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Hardware events follow the command so a set in the clearing cycle survives
    if (program_fail_set || (unit_reprogram && ref_reg.cfg4[MULTIPASS_BIT])) begin
      ref_next.status1[PROG_FAIL_BIT] = 1'b1;
    end
    if (erase_fail_set) begin
      ref_next.status1[ERASE_FAIL_BIT] = 1'b1;
    end
    ref_next.unit_disable = unit_reprogram && !ref_reg.cfg4[MULTIPASS_BIT];
    if (array_read_done) begin
      ref_next.unit_addr = array_read_addr[31:UNIT_ADDR_LSB];
      if (ecc_single_detect) begin
        ref_next.ecc_status[SINGLE_ERR_BIT] = 1'b1;
      end
      // Double-bit detection exists only with multi-pass select set to one
      if (ecc_double_detect && ref_reg.cfg4[MULTIPASS_BIT]) begin
        ref_next.ecc_status[DOUBLE_ERR_BIT] = 1'b1;
      end
    end
    if (signaling_reset) begin
      ref_next.ecc_status       = ECC_STATUS_RESET;
      ref_next.status1[WEL_BIT] = 1'b0;
      ref_next.vol_wen          = 1'b0;
    end
    if (ref_reg.apply_arch || signaling_reset) begin
      ref_next.arch_active = ref_reg.arch_pending;
    end
    ref_next.imp_ohm = impedance_ohm(ref_next.cfg4[IMPEDANCE_MSB:IMPEDANCE_LSB]);
    // Snapshot for the link side stays frozen while a frame is open
    if (ref_reg.cs_sync && ref_reg.cs_prev) begin
      ref_next.snap[3'(REG_STATUS_ONE)] = {ref_reg.status1[7:1], device_busy};
      ref_next.snap[3'(REG_STATUS_TWO)] = STATUS_TWO_VALUE;
      ref_next.snap[3'(REG_CONFIG_ONE)] = ref_reg.cfg1;
      ref_next.snap[3'(REG_CONFIG_TWO)] = ref_reg.cfg2;
      ref_next.snap[3'(REG_CONFIG_THR)] = ref_reg.cfg3;
      ref_next.snap[3'(REG_CONFIG_FOU)] = ref_reg.cfg4;
      ref_next.snap[3'(REG_SECTOR_ARC)] = {4'h0, ref_reg.arch_pending};
      ref_next.snap[3'(REG_ECC_STATUS)] = ref_reg.ecc_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ref_reg <= REF_RESET;
    end else begin
      ref_reg <= ref_next;
    end
  end

  assign serial_output_line      = link_reg.miso;
  assign serial_output_line_oe_n = chip_select_n | ~link_open_reg | link_reg.oe_n;
  assign drive_impedance_sel     = ref_reg.cfg4[IMPEDANCE_MSB:IMPEDANCE_LSB];
  assign drive_impedance_ohm     = ref_reg.imp_ohm;
  assign multipass_ecc_sel       = ref_reg.cfg4[MULTIPASS_BIT];
  assign ecc_unit_disable        = ref_reg.unit_disable;
  assign sector_arch_option      = ref_reg.arch_active;
  assign sector_arch_locked      = ref_reg.arch_locked;
  assign write_enable_latch      = ref_reg.status1[WEL_BIT];
  assign long_address_mode       = ref_reg.cfg2[ADDR_LEN_BIT];
  assign blank_check_enable      = ref_reg.cfg3[BLANK_CHECK_BIT];
  assign erase_error_flag        = ref_reg.status1[ERASE_FAIL_BIT];
  assign program_error_flag      = ref_reg.status1[PROG_FAIL_BIT];
  assign double_bit_error_flag   = ref_reg.ecc_status[DOUBLE_ERR_BIT];
  assign single_bit_error_flag   = ref_reg.ecc_status[SINGLE_ERR_BIT];
  assign single_bit_flag_valid   = ~ref_reg.ecc_status[DOUBLE_ERR_BIT];
  assign ecc_unit_addr           = ref_reg.unit_addr;

endmodule

// ===== rtl/sfra_pkg.sv
// Shared constants, register map and address decoder for the serial flash register-access block
package sfra_pkg;

  // Command opcodes, single-wire protocol
  localparam logic [7:0] CMD_READ_IDENTIFICATION = 8'h9F;
  localparam logic [7:0] CMD_READ_PARAM_TABLE    = 8'h5A;
  localparam logic [7:0] CMD_READ_UNIQUE_NUMBER  = 8'h4C;
  localparam logic [7:0] CMD_READ_STATUS_ONE     = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_TWO     = 8'h07;
  localparam logic [7:0] CMD_READ_CONFIG_ONE     = 8'h35;
  localparam logic [7:0] CMD_READ_ANY_REGISTER   = 8'h65;
  localparam logic [7:0] CMD_WRITE_ENABLE        = 8'h06;
  localparam logic [7:0] CMD_VOLATILE_WR_ENABLE  = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE       = 8'h04;
  localparam logic [7:0] CMD_WRITE_REGISTERS     = 8'h01;
  localparam logic [7:0] CMD_WRITE_ANY_REGISTER  = 8'h71;
  localparam logic [7:0] CMD_CLEAR_FAIL_FLAGS    = 8'h82;
  localparam logic [7:0] CMD_ENTER_LONG_ADDRESS  = 8'hB7;
  localparam logic [7:0] CMD_EXIT_LONG_ADDRESS   = 8'hB8;
  localparam logic [7:0] CMD_CLEAR_ECC_STATUS    = 8'h1B;

  // Field positions
  localparam int BUSY_BIT        = 0;
  localparam int WEL_BIT         = 1;
  localparam int ERASE_FAIL_BIT  = 5;
  localparam int PROG_FAIL_BIT   = 6;
  localparam int PERM_LOCK_BIT   = 4;
  localparam int ADDR_LEN_BIT    = 7;
  localparam int BLANK_CHECK_BIT = 5;
  localparam int MULTIPASS_BIT   = 3;
  localparam int IMPEDANCE_MSB   = 7;
  localparam int IMPEDANCE_LSB   = 5;
  localparam int DOUBLE_ERR_BIT  = 4;
  localparam int SINGLE_ERR_BIT  = 3;
  localparam int ARCH_OPT_MSB    = 3;
  localparam int UNIT_ADDR_LSB   = 4;

  // Write masks: bits that a register write may change
  localparam logic [7:0] STATUS_ONE_WMASK = 8'h9C;
  localparam logic [7:0] CONFIG_ONE_WMASK = 8'h23;
  localparam logic [7:0] CONFIG_TWO_WMASK = 8'h87;
  localparam logic [7:0] CONFIG_THR_WMASK = 8'h30;
  localparam logic [7:0] CONFIG_FOU_WMASK = 8'hE8;

  // Reset values
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] STATUS_TWO_VALUE = 8'h00;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h02;
  localparam logic [7:0] CONFIG_TWO_RESET = 8'h80;
  localparam logic [7:0] CONFIG_THR_RESET = 8'h20;
  localparam logic [7:0] CONFIG_FOU_RESET = 8'h08;
  localparam logic [7:0] ECC_STATUS_RESET = 8'h00;

  // Register addresses for read-any / write-any
  localparam logic [31:0] ADDR_STATUS_ONE = 32'h0080_0000;
  localparam logic [31:0] ADDR_STATUS_TWO = 32'h0080_0001;
  localparam logic [31:0] ADDR_CONFIG_ONE = 32'h0080_0002;
  localparam logic [31:0] ADDR_CONFIG_TWO = 32'h0080_0003;
  localparam logic [31:0] ADDR_CONFIG_THR = 32'h0080_0004;
  localparam logic [31:0] ADDR_CONFIG_FOU = 32'h0080_0005;
  localparam logic [31:0] ADDR_SECTOR_ARC = 32'h0000_0006;
  localparam logic [31:0] ADDR_ECC_STATUS = 32'h0080_0089;

  // Framing: one dummy byte ahead of parameter-table and read-any data
  localparam logic [8:0] SHORT_READ_START = 9'h001;
  localparam logic [8:0] DUMMY_BYTES      = 9'h001;
  localparam logic [8:0] UNIQUE_BYTES     = 9'h008;

  typedef enum logic [3:0] {
    REG_STATUS_ONE, REG_STATUS_TWO, REG_CONFIG_ONE, REG_CONFIG_TWO,
    REG_CONFIG_THR, REG_CONFIG_FOU, REG_SECTOR_ARC, REG_ECC_STATUS, REG_NONE
  } sfra_reg_e;

  function automatic sfra_reg_e sfra_decode(input logic [31:0] addr);
    case (addr)
      ADDR_STATUS_ONE: sfra_decode = REG_STATUS_ONE;
      ADDR_STATUS_TWO: sfra_decode = REG_STATUS_TWO;
      ADDR_CONFIG_ONE: sfra_decode = REG_CONFIG_ONE;
      ADDR_CONFIG_TWO: sfra_decode = REG_CONFIG_TWO;
      ADDR_CONFIG_THR: sfra_decode = REG_CONFIG_THR;
      ADDR_CONFIG_FOU: sfra_decode = REG_CONFIG_FOU;
      ADDR_SECTOR_ARC: sfra_decode = REG_SECTOR_ARC;
      ADDR_ECC_STATUS: sfra_decode = REG_ECC_STATUS;
      default:         sfra_decode = REG_NONE;
    endcase
  endfunction

endpackage

// ===== verification/sfra_checker.sv
// Port assertions for the register-access core
`timescale 1ns/1ps
module sfra_checker (
  input wire logic        ref_clk, resetn, chip_select_n, serial_output_line_oe_n,
  input wire logic        signaling_reset, array_read_done, ecc_double_detect,
  input wire logic        unit_reprogram, multipass_ecc_sel, ecc_unit_disable,
  input wire logic        write_enable_latch, double_bit_error_flag,
  input wire logic [31:0] array_read_addr,
  input wire logic [2:0]  drive_impedance_sel,
  input wire logic [7:0]  drive_impedance_ohm,
  input wire logic [3:0]  sector_arch_option,
  input wire logic [27:0] ecc_unit_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_oe; chip_select_n |-> serial_output_line_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_ohm; drive_impedance_sel == 3'h7 && $stable(drive_impedance_sel)
    |-> drive_impedance_ohm == 8'h0F; endproperty
  a_ohm: assert property (p_ohm) else $error("ohm");
  property p_dis; unit_reprogram && !multipass_ecc_sel |=> ecc_unit_disable; endproperty
  a_dis: assert property (p_dis) else $error("dis");
  property p_dbl; array_read_done && ecc_double_detect && multipass_ecc_sel
    |=> double_bit_error_flag; endproperty
  a_dbl: assert property (p_dbl) else $error("dbl");
  // Command clearing lands only after a frame closes; signaling reset can clear inside one
  property p_hold; double_bit_error_flag && !chip_select_n && !signaling_reset
    |=> double_bit_error_flag; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_addr; array_read_done
    |=> ecc_unit_addr == 28'($past(array_read_addr) >> 4); endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_arch; !$stable(sector_arch_option)
    |-> $past(signaling_reset) || $past(signaling_reset, 2) || !$past(resetn, 2); endproperty
  a_arch: assert property (p_arch) else $error("arch");
  property p_wel; $rose(write_enable_latch) |-> chip_select_n; endproperty
  a_wel: assert property (p_wel) else $error("wel");
endmodule
bind sfra_core sfra_checker u_sfra_checker (.*);

// ===== verification/sfra_host_model.sv
// Host SPI controller model, mode 0
`timescale 1ns/1ps
module sfra_host_model (
  output logic      serial_clk, chip_select_n, serial_input_line,
  input wire logic  serial_output_line
);
  // Real rising select at start, else the frame-open flag stays unknown
  initial begin
    {serial_clk, chip_select_n, serial_input_line} = 3'b000;
    #1 chip_select_n = 1'b1;
  end
  // 48 ns period keeps every read under the table read ceiling
  task automatic frame(input logic [63:0] tx, input int ntx, nrx,
                       output logic [63:0] rx);
    rx = '0;
    #5 chip_select_n = 1'b0;
    for (int i = 0; i < 8 * (ntx + nrx); i++) begin
      serial_input_line = i < 8 * ntx ? tx[8 * ntx - 1 - i] : ~serial_input_line;
      #24 if (i >= 8 * ntx) rx = {rx[62:0], serial_output_line};
      serial_clk = 1'b1;
      #24 serial_clk = 1'b0;
    end
    #24 chip_select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_input_line = ~serial_input_line;
    #200;
  endtask
endmodule

// ===== verification/sfra_core_test.sv
// Self-checking bench for the register-access core
`timescale 1ns/1ps
module sfra_core_test;
  typedef struct {logic [63:0] tx; int ntx; int nrx; logic [63:0] exp;} sfra_row_s;
  logic ref_clk = 0, resetn = 1, signaling_reset = 0, device_busy = 0, array_read_done = 0;
  logic ecc_single_detect = 0, ecc_double_detect = 0, unit_reprogram = 0;
  logic program_fail_set = 0, erase_fail_set = 0;
  logic [31:0] array_read_addr = 0;
  logic [63:0] rx;
  wire serial_clk, chip_select_n, serial_input_line, serial_output_line, serial_output_line_oe_n;
  wire [2:0] drive_impedance_sel;
  wire [7:0] drive_impedance_ohm;
  wire [3:0] sector_arch_option;
  wire [27:0] ecc_unit_addr;
  wire multipass_ecc_sel, ecc_unit_disable, sector_arch_locked, write_enable_latch;
  wire long_address_mode, blank_check_enable, erase_error_flag, program_error_flag;
  wire double_bit_error_flag, single_bit_error_flag, single_bit_flag_valid;
  int errors = 0, checks_done = 0, cycles = 0;
  sfra_row_s rows [9];
  sfra_core u_sfra_core (.*);
  sfra_host_model u_sfra_host_model (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic check(input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [63:0] tx, input int ntx = 1);
    u_sfra_host_model.frame(tx, ntx, 0, rx);
  endtask
  task automatic sig_reset;
    @(posedge ref_clk) signaling_reset <= 1'b1;
    @(posedge ref_clk) signaling_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic read_unit(input logic [31:0] a, input logic s, d);
    @(posedge ref_clk);
    {array_read_addr, ecc_single_detect, ecc_double_detect, array_read_done} <= {a, s, d, 1'b1};
    @(posedge ref_clk) array_read_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Ceiling well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    // Falling edge needed so the link flops take their asynchronous reset
    resetn <= 1'b0;
    rows = '{'{64'h05, 1, 1, 64'h00}, '{64'h07, 1, 1, 64'h00}, '{64'h35, 1, 1, 64'h02},
      '{64'h9F, 1, 3, 64'hA53C5A}, '{64'h4C, 1, 8, 64'h0123456789ABCDEF},
      '{64'h65_0080_0005_00, 6, 1, 64'h08}, '{64'h65_0080_0089_00, 6, 1, 64'h00},
      '{64'h65_0080_0003_00, 6, 1, 64'h80}, '{64'h5A_0000_0000, 5, 4, 64'h5346_4450}};
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) begin
      u_sfra_host_model.frame(rows[i].tx, rows[i].ntx, rows[i].nrx, rx);
      check(rx, rows[i].exp);
    end
    $display("register reads done");
    cmd(64'h71_0080_0005_F0, 6);
    check(drive_impedance_sel, 0);
    cmd(64'h06);
    check(write_enable_latch, 1);
    cmd(64'h04);
    check(write_enable_latch, 0);
    cmd(64'h06);
    cmd(64'h71_0080_0005_F0, 6);
    check({drive_impedance_ohm, multipass_ecc_sel}, {8'h0F, 1'b0});
    @(posedge ref_clk) unit_reprogram <= 1'b1;
    @(posedge ref_clk) unit_reprogram <= 1'b0;
    #1 check(ecc_unit_disable, 1);
    cmd(64'h06);
    cmd(64'h01_00_02_00_20_28_03, 7);
    check({long_address_mode, drive_impedance_ohm, multipass_ecc_sel}, 10'h0F1);
    check({sector_arch_locked, sector_arch_option}, 5'h10);
    cmd(64'hB7);
    check(long_address_mode, 1);
    cmd(64'hB8);
    check(long_address_mode, 0);
    sig_reset();
    check(sector_arch_option, 3);
    cmd(64'h06);
    cmd(64'h01_00_02_00_00_28_05, 7);
    sig_reset();
    check(sector_arch_option, 3);
    check(blank_check_enable, 0);
    $display("config tests done");
    read_unit(32'h1234_5678, 1'b1, 1'b1);
    check({double_bit_error_flag, single_bit_error_flag, single_bit_flag_valid}, 3'b110);
    check(ecc_unit_addr, 28'h123_4567);
    read_unit(32'h0000_0000, 1'b0, 1'b0);
    cmd(64'h1B);
    check(double_bit_error_flag, 1);
    cmd(64'h06);
    cmd(64'h1B);
    check({double_bit_error_flag, single_bit_error_flag}, 0);
    @(posedge ref_clk) {program_fail_set, erase_fail_set} <= 2'b11;
    @(posedge ref_clk) {program_fail_set, erase_fail_set} <= 2'b00;
    #1 check({program_error_flag, erase_error_flag}, 3);
    cmd(64'h06);
    cmd(64'h82);
    check({program_error_flag, erase_error_flag}, 0);
    $display("flag tests done");
    conclude();
  end
endmodule
